// ### rscp_pkg.sv
// shared constants for the radio serial config port
package rscp_pkg;
	localparam int          CLK_MHZ         = 100;
	localparam int          WRITE_SETUP_US  = 20;
	localparam int          WRITE_SETUP_CYC = WRITE_SETUP_US * CLK_MHZ;
	localparam int          HALF_SCLK_CYC   = 25;
	localparam logic [6:0]  ADDR_CHAN       = 7'h00;
	localparam logic [6:0]  ADDR_PWR        = 7'h01;
	localparam logic [6:0]  ADDR_FUNC       = 7'h02;
	localparam logic [6:0]  ADDR_STRENGTH   = 7'h03;
	localparam logic [6:0]  ADDR_LAST_USER  = 7'h18;
	localparam logic [7:0]  RST_CHAN        = 8'h28;
	localparam logic [7:0]  RST_PWR         = 8'h03;
	localparam logic [7:0]  RST_FUNC        = 8'h78;
	localparam logic [7:0]  RST_STRENGTH    = 8'h87;
	localparam int          BIT_DIR         = 7;
	localparam int          BIT_BURST       = 6;
	localparam int          BIT_RATE        = 5;
	localparam int          BIT_SCRAMBLE    = 4;
	localparam int          BIT_CRC         = 3;
	localparam int          BIT_KEEP_BAD    = 0;
	localparam int          BIT_REFRESH     = 4;
	localparam logic [7:0]  MASK_PWR        = 8'h1f;
	localparam logic [7:0]  MASK_FUNC       = 8'h79;
	localparam logic [7:0]  MASK_STRENGTH   = 8'h1f;
	localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;
	localparam logic [7:0]  HOST_OFS_CMD    = 8'h00;
	localparam logic [7:0]  HOST_OFS_DATA   = 8'h01;
	localparam logic [7:0]  HOST_OFS_STATUS = 8'h02;
	localparam logic [7:0]  HOST_OFS_RESULT = 8'h03;
	localparam logic [7:0]  HOST_OFS_FIFO   = 8'h04;
endpackage : rscp_pkg

// ### rscp_if.sv
// serial link between host and radio config port
`timescale 1ns/100ps
`default_nettype none
interface rscp_if;
	logic sclk;
	logic select;
	logic data_host_out;
	logic data_host_oe_n;
	logic data_dev_out;
	logic data_dev_oe_n;
	logic serial_data_line;
	// the wire pulls high when nobody drives
	assign serial_data_line = !data_host_oe_n ? data_host_out :
		(!data_dev_oe_n ? data_dev_out : 1'b1);
	modport host (output sclk, output select, output data_host_out,
		output data_host_oe_n, input serial_data_line);
	modport dev (input sclk, input select, output data_dev_out,
		output data_dev_oe_n, input serial_data_line);
endinterface : rscp_if
`default_nettype wire

// ### rscp_sync.sv
// two-flop synchroniser for a group of link inputs
`timescale 1ns/100ps
`default_nettype none
module rscp_sync #(
	parameter int W = 3
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_sync;
	// first stage feeds only the second
	always_comb begin
		next_meta = i_async;
		next_sync = meta;
	end
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			meta   <= '0;
			o_sync <= '0;
		end else begin
			meta   <= next_meta;
			o_sync <= next_sync;
		end
	end
endmodule : rscp_sync
`default_nettype wire

// ### rscp_dev.sv
// radio end: serial config port and first four configuration registers
`timescale 1ns/100ps
`default_nettype none
module rscp_dev
	import rscp_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	rscp_if.dev             link,
	input  wire logic [3:0] i_strength_level,
	input  wire logic [7:0] i_fifo_rd_data,
	output logic            o_tx_mode,
	output logic [6:0]      o_channel_number,
	output logic [1:0]      o_tx_output_level,
	output logic [2:0]      o_crystal_sel,
	output logic            o_burst_mode,
	output logic            o_air_rate_select,
	output logic            o_scramble_en,
	output logic            o_crc_en,
	output logic            o_keep_bad_packet,
	output logic            o_strength_refresh,
	output logic            o_strength_above_pin,
	output logic            o_fifo_wr,
	output logic [7:0]      o_fifo_wr_data,
	output logic            o_fifo_rd
);
	logic [2:0] pins;
	logic       sclk_s, sel_s, din_s;
	logic       sclk_d, next_sclk_d;
	logic       rise, fall;
	logic [7:0] reg_chan, reg_pwr, reg_func, reg_str;
	logic [7:0] next_chan, next_pwr, next_func, next_str;
	logic [7:0] shreg, next_shreg;
	logic [7:0] cmd, next_cmd;
	logic [3:0] bitcnt, next_bitcnt;
	logic       second, next_second;
	logic       done, next_done;
	logic       dout, next_dout;
	logic       oe_n, next_oe_n;
	logic       fwr, next_fwr, frd, next_frd;
	logic [7:0] rdval;
	logic [7:0] addr_val;
	logic       above, next_above;

	rscp_sync #(.W(3)) u_sync (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_async ({link.sclk, link.select, link.serial_data_line}),
		.o_sync  (pins)
	);
	assign {sclk_s, sel_s, din_s} = pins;
	assign rise = sclk_s && !sclk_d;
	assign fall = !sclk_s && sclk_d;

	// register read decode, unknown addresses in range read zero
	function automatic logic [7:0] reg_read(input logic [6:0] a, input logic [7:0] c,
		input logic [7:0] p, input logic [7:0] f, input logic [7:0] s);
		case (a)
			ADDR_CHAN:     reg_read = c;
			ADDR_PWR:      reg_read = p;
			ADDR_FUNC:     reg_read = f;
			ADDR_STRENGTH: reg_read = s;
			default:       reg_read = 8'h00;
		endcase
	endfunction : reg_read
	assign rdval = reg_read(cmd[6:0], reg_chan, reg_pwr, reg_func, reg_str);
	// value of the register named by the address byte now in the shifter
	assign addr_val = reg_read(shreg[6:0], reg_chan, reg_pwr, reg_func, reg_str);

	// serial engine: one transaction per select-high window
	always_comb begin
		next_sclk_d = sclk_s;
		next_shreg  = shreg;
		next_cmd    = cmd;
		next_bitcnt = bitcnt;
		next_second = second;
		next_done   = done;
		next_dout   = dout;
		next_oe_n   = oe_n;
		next_fwr    = 1'b0;
		next_frd    = 1'b0;
		next_chan   = reg_chan;
		next_pwr    = reg_pwr;
		next_func   = reg_func;
		next_str    = reg_str;
		if (sel_s) begin
			// the address byte comes from the host, so let go of the line at once
			if (!second) next_oe_n = 1'b1;
			if (rise && !done) begin
				next_shreg  = {shreg[6:0], din_s};
				next_bitcnt = bitcnt + 4'h1;
			end
			// byte completes on falling edge after its eighth sample
			if (fall && bitcnt == BITS_PER_BYTE && !done) begin
				next_bitcnt = 4'h0;
				if (!second) begin
					next_cmd    = shreg;
					next_second = 1'b1;
					if (!shreg[BIT_DIR]) begin
						next_oe_n  = 1'b0;
						next_dout  = addr_val[7];
						next_shreg = addr_val;
					end
				end else begin
					next_done = 1'b1;
					next_oe_n = 1'b1;
					if (cmd[BIT_DIR] && cmd[6:0] <= ADDR_LAST_USER) begin
						case (cmd[6:0])
							ADDR_CHAN:     next_chan = shreg;
							ADDR_PWR:      next_pwr  = shreg & MASK_PWR;
							ADDR_FUNC:     next_func = shreg & MASK_FUNC;
							ADDR_STRENGTH: next_str  = shreg & MASK_STRENGTH;
							default:       next_chan = reg_chan;
						endcase
					end
				end
			end else if (fall && second && !oe_n && !cmd[BIT_DIR]) begin
				next_dout = rdval[7 - bitcnt[2:0]];
			end
		end else begin
			// select low: port reset, FIFO transfer in burst mode
			next_bitcnt = 4'h0;
			next_second = 1'b0;
			next_done   = 1'b0;
			next_oe_n   = 1'b1;
			if (reg_func[BIT_BURST]) begin
				if (rise) begin
					next_shreg  = {shreg[6:0], din_s};
					next_bitcnt = bitcnt + 4'h1;
				end else begin
					next_bitcnt = bitcnt;
				end
				if (fall && bitcnt == BITS_PER_BYTE) begin
					next_bitcnt = 4'h0;
					next_fwr    = reg_chan[BIT_DIR];
					next_frd    = !reg_chan[BIT_DIR];
				end
				if (!reg_chan[BIT_DIR]) begin
					next_oe_n = 1'b0;
					next_dout = i_fifo_rd_data[7 - bitcnt[2:0]];
				end
			end
		end
	end

	// digital strength comparator
	always_comb begin
		next_above = i_strength_level > reg_str[3:0];
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			sclk_d   <= 1'b0;
			shreg    <= 8'h00;
			cmd      <= 8'h00;
			bitcnt   <= 4'h0;
			second   <= 1'b0;
			done     <= 1'b0;
			dout     <= 1'b1;
			oe_n     <= 1'b1;
			fwr      <= 1'b0;
			frd      <= 1'b0;
			reg_chan <= RST_CHAN;
			reg_pwr  <= RST_PWR;
			reg_func <= RST_FUNC;
			reg_str  <= RST_STRENGTH;
			above    <= 1'b0;
		end else begin
			sclk_d   <= next_sclk_d;
			shreg    <= next_shreg;
			cmd      <= next_cmd;
			bitcnt   <= next_bitcnt;
			second   <= next_second;
			done     <= next_done;
			dout     <= next_dout;
			oe_n     <= next_oe_n;
			fwr      <= next_fwr;
			frd      <= next_frd;
			reg_chan <= next_chan;
			reg_pwr  <= next_pwr;
			reg_func <= next_func;
			reg_str  <= next_str;
			above    <= next_above;
		end
	end

	// outputs straight from registers
	assign link.data_dev_out   = dout;
	assign link.data_dev_oe_n  = oe_n;
	assign o_tx_mode           = reg_chan[BIT_DIR];
	assign o_channel_number    = reg_chan[6:0];
	assign o_tx_output_level   = reg_pwr[4:3];
	assign o_crystal_sel       = reg_pwr[2:0];
	assign o_burst_mode        = reg_func[BIT_BURST];
	assign o_air_rate_select   = reg_func[BIT_RATE];
	assign o_scramble_en       = reg_func[BIT_SCRAMBLE];
	assign o_crc_en            = reg_func[BIT_CRC];
	assign o_keep_bad_packet   = reg_func[BIT_KEEP_BAD];
	assign o_strength_refresh  = reg_str[BIT_REFRESH];
	assign o_strength_above_pin = above;
	assign o_fifo_wr           = fwr;
	assign o_fifo_wr_data      = shreg;
	assign o_fifo_rd           = frd;
endmodule : rscp_dev
`default_nettype wire

// ### rscp_host.sv
// host end: drives serial clock and select from a small command port
`timescale 1ns/100ps
`default_nettype none
module rscp_host
	import rscp_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	rscp_if.host            link,
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic [7:0]      o_rdata
);
	typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_LOW, ST_HIGH, ST_GAP} rscp_state_t;
	rscp_state_t st, next_st;
	logic [15:0] cnt, next_cnt;
	logic [15:0] sh, next_sh;
	logic [4:0]  nbits, next_nbits;
	logic [7:0]  cmd, next_cmd, dat, next_dat, res, next_res;
	logic        busy, next_busy, sel, next_sel, sclk, next_sclk;
	logic        oe_n, next_oe_n, isreg, next_isreg;
	logic [7:0]  rdata, next_rdata;
	logic        din_s;
	logic [15:0] waitc;

	rscp_sync #(.W(1)) u_sync (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_async (link.serial_data_line),
		.o_sync  (din_s)
	);
	// setup wait is long whenever the stored command is a write, FIFO transfers included
	assign waitc = cmd[BIT_DIR] ? 16'(WRITE_SETUP_CYC) : 16'(HALF_SCLK_CYC);

	// transfer sequencer and register port
	always_comb begin
		next_st = st; next_cnt = cnt; next_sh = sh; next_nbits = nbits;
		next_cmd = cmd; next_dat = dat; next_res = res; next_busy = busy;
		next_sel = sel; next_sclk = sclk; next_oe_n = oe_n; next_isreg = isreg;
		next_rdata = 8'h00;
		if (i_rd) begin
			case (i_addr)
				HOST_OFS_CMD:    next_rdata = cmd;
				HOST_OFS_DATA:   next_rdata = dat;
				HOST_OFS_STATUS: next_rdata = {7'h00, busy};
				HOST_OFS_RESULT: next_rdata = res;
				default:         next_rdata = 8'h00;
			endcase
		end
		if (i_wr && i_addr == HOST_OFS_DATA) next_dat = i_wdata;
		case (st)
			ST_IDLE: begin
				next_sel = 1'b0;
				if (i_wr && (i_addr == HOST_OFS_CMD || i_addr == HOST_OFS_FIFO)) begin
					next_isreg = (i_addr == HOST_OFS_CMD);
					next_cmd   = (i_addr == HOST_OFS_CMD) ? i_wdata : cmd;
					next_sh    = (i_addr == HOST_OFS_CMD) ? {i_wdata, dat} : {i_wdata, 8'h00};
					next_nbits = (i_addr == HOST_OFS_CMD) ? 5'd16 : 5'd8;
					next_sel   = (i_addr == HOST_OFS_CMD);
					next_busy  = 1'b1;
					next_cnt   = 16'h0;
					next_st    = ST_SETUP;
				end
			end
			ST_SETUP: begin
				next_cnt = cnt + 16'h1;
				if (cnt >= waitc) begin
					next_cnt = 16'h0; next_oe_n = 1'b0; next_st = ST_LOW;
				end
			end
			ST_LOW: begin
				next_cnt = cnt + 16'h1;
				if (cnt >= 16'(HALF_SCLK_CYC)) begin
					next_cnt = 16'h0; next_sclk = 1'b1; next_st = ST_HIGH;
				end
			end
			ST_HIGH: begin
				next_cnt = cnt + 16'h1;
				if (cnt >= 16'(HALF_SCLK_CYC)) begin
					next_cnt = 16'h0; next_sclk = 1'b0;
					next_res = {res[6:0], din_s};
					next_sh = {sh[14:0], 1'b0}; next_nbits = nbits - 5'd1;
					// release the line after a read address byte
					if (isreg && nbits == 5'd9 && !cmd[BIT_DIR]) next_oe_n = 1'b1;
					next_st = (nbits == 5'd1) ? ST_GAP : ST_LOW;
				end
			end
			ST_GAP: begin
				next_cnt = cnt + 16'h1;
				next_oe_n = 1'b1;
				// drop select half-way through the gap, then hold it low for the rest so the far end resets
				if (cnt >= 16'(HALF_SCLK_CYC)) next_sel = 1'b0;
				if (cnt >= 16'(2 * HALF_SCLK_CYC)) begin
					next_busy = 1'b0;
					next_st = ST_IDLE;
				end
			end
			default: next_st = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			st <= ST_IDLE; cnt <= 16'h0; sh <= 16'h0; nbits <= 5'd0;
			cmd <= 8'h00; dat <= 8'h00; res <= 8'h00; busy <= 1'b0;
			sel <= 1'b0; sclk <= 1'b0; oe_n <= 1'b1; isreg <= 1'b0; rdata <= 8'h00;
		end else begin
			st <= next_st; cnt <= next_cnt; sh <= next_sh; nbits <= next_nbits;
			cmd <= next_cmd; dat <= next_dat; res <= next_res; busy <= next_busy;
			sel <= next_sel; sclk <= next_sclk; oe_n <= next_oe_n; isreg <= next_isreg;
			rdata <= next_rdata;
		end
	end

	assign link.sclk           = sclk;
	assign link.select         = sel;
	assign link.data_host_out  = sh[15];
	assign link.data_host_oe_n = oe_n;
	assign o_rdata             = rdata;
endmodule : rscp_host
`default_nettype wire

// ### rscp_properties.sv
// link-level checks for the radio serial config port
`timescale 1ns/100ps
`default_nettype none
module rscp_properties (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic sclk,
	input wire logic select,
	input wire logic data_host_out,
	input wire logic data_host_oe_n,
	input wire logic data_dev_out,
	input wire logic data_dev_oe_n
);
	// one domain, so one clocking and one disable for all checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	// a dropped select must stay low long enough to reset the port
	select_low_gap_a: assert property ($fell(select) |-> !select [*8])
		else $error("select pulsed low too briefly");
	// host makes sclk from a divider, so each phase lasts many cycles
	sclk_high_phase_a: assert property ($rose(sclk) |-> sclk [*8])
		else $error("sclk high phase too short");
	sclk_low_phase_a: assert property ($fell(sclk) |-> !sclk [*8])
		else $error("sclk low phase too short");
	// select never moves while sclk is high, checked in the high phases only
	select_in_frame_a: assert property (sclk |-> $stable(select))
		else $error("select moved during a clock pulse");
	// register-frame bits only change on the falling edge, so they hold while sclk is high
	host_bit_hold_a: assert property (sclk && !data_host_oe_n |-> $stable(data_host_out))
		else $error("host data changed while sclk high");
	dev_bit_hold_a: assert property (sclk && !data_dev_oe_n |-> $stable(data_dev_out))
		else $error("device data changed while sclk high");
	// the address byte always comes from the host
	// the radio end sees select through its synchroniser, three cycles late
	addr_byte_host_a: assert property ($rose(select) |-> ##3 data_dev_oe_n [*8])
		else $error("device drove data during address byte");
	// a quiet setup time before the first clock of a transaction
	select_setup_a: assert property ($rose(select) |-> !sclk [*8])
		else $error("sclk started right after select");
	no_contention_a: assert property (!(!data_host_oe_n && !data_dev_oe_n))
		else $error("both ends drive the data line");

	cover property ($rose(select));
	cover property ($fell(data_dev_oe_n));
	cover property ($fell(select) ##1 !select);
endmodule : rscp_properties
`default_nettype wire

// ### tb_radio_serial_config_port.sv
// self-checking bench: host end and radio end joined over the link
`timescale 1ns/100ps
`default_nettype none
module tb_radio_serial_config_port;
	import rscp_pkg::*;
	logic        i_clk;
	logic        i_rst_n;
	logic [7:0]  addr;
	logic [7:0]  wdata;
	logic        wr;
	logic        rd;
	logic [7:0]  rdata;
	logic [3:0]  level;
	logic        tx_mode, burst, rate, scr, crc, keep, refresh, above;
	logic [6:0]  chan;
	logic [1:0]  tx_output_level;
	logic [2:0]  xtal;
	logic        sclk_q, sel_q;
	logic [15:0] frame;
	int          nbits;
	int          failures;
	int          checked;
	logic [7:0]  got;
	logic        fifo_wr;
	logic [7:0]  fifo_wr_data;
	logic [7:0]  fifo_rd;
	logic [7:0]  fifo_seen;
	int          fifo_cnt = 0;
	// reserved bits are written as zero in the four rows of implemented registers
	// rows: register address, value written, value read back
	logic [23:0] rows [5] = '{24'h008585, 24'h011414, 24'h022121, 24'h031a1a, 24'h105a00};

	rscp_if lnk();
	rscp_host u_rscp_host (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(lnk), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata));
	rscp_dev u_rscp_dev (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(lnk),
		.i_strength_level(level), .i_fifo_rd_data(fifo_rd), .o_tx_mode(tx_mode),
		.o_channel_number(chan), .o_tx_output_level(tx_output_level), .o_crystal_sel(xtal),
		.o_burst_mode(burst), .o_air_rate_select(rate), .o_scramble_en(scr),
		.o_crc_en(crc), .o_keep_bad_packet(keep), .o_strength_refresh(refresh),
		.o_strength_above_pin(above), .o_fifo_wr(fifo_wr), .o_fifo_wr_data(fifo_wr_data),
		.o_fifo_rd());
	rscp_properties u_rscp_properties (.i_clk(i_clk), .i_rst_n(i_rst_n), .sclk(lnk.sclk),
		.select(lnk.select), .data_host_out(lnk.data_host_out),
		.data_host_oe_n(lnk.data_host_oe_n), .data_dev_out(lnk.data_dev_out),
		.data_dev_oe_n(lnk.data_dev_oe_n));

	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	// wire monitor: sample the resolved line on each sclk rise in a frame
	always @(posedge i_clk) begin
		sclk_q <= lnk.sclk;
		sel_q <= lnk.select;
		if (lnk.select && !sel_q) begin
			nbits <= 0;
		end else if (lnk.select && lnk.sclk && !sclk_q) begin
			frame <= {frame[14:0], lnk.serial_data_line};
			nbits <= nbits + 1;
		end
	end

	// catch bytes the radio end pushes into its transmit FIFO
	always @(posedge i_clk) begin
		if (fifo_wr) begin
			fifo_seen <= fifo_wr_data;
			fifo_cnt <= fifo_cnt + 1;
		end
	end

	task automatic check(input string what, input logic [23:0] exp, input logic [23:0] seen);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic give_verdict;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : give_verdict

	// one-cycle strobes on the host command port
	task automatic host_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge i_clk);
		wr <= 1'b0;
	endtask : host_wr

	task automatic host_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge i_clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : host_rd

	// poll status until the host end is idle; running out counts as a mismatch
	task automatic wait_idle;
		logic [7:0] s;
		s = 8'h01;
		for (int i = 0; i < 6000 && s[0] !== 1'b0; i++) host_rd(HOST_OFS_STATUS, s);
		check("busy cleared", 24'h0, 24'(s[0]));
	endtask : wait_idle

	// full register transaction, then the wire frame is compared
	task automatic xact(input logic dir, input logic [6:0] a, input logic [7:0] d,
		output logic [7:0] r);
		host_wr(HOST_OFS_DATA, d);
		host_wr(HOST_OFS_CMD, {dir, a});
		wait_idle();
		host_rd(HOST_OFS_RESULT, r);
		check("bits per frame", 24'd16, 24'(nbits));
		check("frame", {8'h0, dir, a, dir ? d : r}, {8'h0, frame});
	endtask : xact

	initial begin
		i_rst_n = 1'b0;
		{addr, wdata, wr, rd, fifo_rd} = '0;
		level = 4'h0;
		failures = 0;
		checked = 0;
		repeat (3) @(posedge i_clk);
		i_rst_n <= 1'b1;
		// power-up register values, read over the link
		foreach (rows[i]) if (i < 4) begin
			xact(1'b0, rows[i][22:16], 8'h00, got);
			check("reset value",
				24'({RST_CHAN, RST_PWR, RST_FUNC, RST_STRENGTH} >> (8 * (3 - i)) & 8'hff), got);
		end
		check("default fields", {8'h28, 5'h03, 5'h1e, 1'b0},
			{tx_mode, chan, tx_output_level, xtal, burst, rate, scr, crc, keep, refresh});
		// each row: write, then a separate read transaction
		foreach (rows[i]) begin
			xact(1'b1, rows[i][22:16], rows[i][15:8], got);
			xact(1'b0, rows[i][22:16], 8'h00, got);
			check("read back", rows[i][7:0], got);
		end
		check("written fields", {8'h85, 5'h14, 5'h09, 1'b1},
			{tx_mode, chan, tx_output_level, xtal, burst, rate, scr, crc, keep, refresh});
		// threshold is 0xa: above only when strictly greater
		level <= 4'hb;
		repeat (6) @(posedge i_clk);
		check("strength above", 24'h1, 24'(above));
		level <= 4'ha;
		repeat (6) @(posedge i_clk);
		check("strength at threshold", 24'h0, 24'(above));
		// burst transmit: a byte sent with select low lands in the FIFO once
		xact(1'b1, ADDR_FUNC, 8'h61, got);
		host_wr(HOST_OFS_FIFO, 8'hc3);
		wait_idle();
		check("fifo byte", 24'hc3, 24'(fifo_seen));
		check("fifo writes", 24'h1, 24'(fifo_cnt));
		// second reset mid-run restores defaults
		i_rst_n <= 1'b0;
		repeat (3) @(posedge i_clk);
		i_rst_n <= 1'b1;
		#1 check("select after reset", 24'h0, 24'(lnk.select));
		// burst receive by default: the radio end drives FIFO data, not the pull-up
		repeat (4) @(posedge i_clk);
		check("fifo read drive", 24'h0, 24'(lnk.serial_data_line));
		xact(1'b0, ADDR_CHAN, 8'h00, got);
		check("channel after reset", 24'(RST_CHAN), 24'(got));
		give_verdict();
	end

	// watchdog well beyond the expected run of about 30000 cycles
	initial begin
		repeat (90000) @(posedge i_clk);
		failures++;
		give_verdict();
	end
endmodule : tb_radio_serial_config_port
`default_nettype wire
